// *** hdl/wdtul_consts.svh ***
// offsets, field positions, reset values and timing counts for the watchdog
`ifndef WDTUL_CONSTS_SVH
`define WDTUL_CONSTS_SVH
`define WDTUL_OFF_CTL      12'hFF0
`define WDTUL_OFF_UPPER    12'hFF1
`define WDTUL_OFF_HIGH     12'hFF2
`define WDTUL_OFF_LOW      12'hFF3
`define WDTUL_OFF_STAT     12'hFF4
`define WDTUL_OFF_MASK     12'hFF5
`define WDTUL_OFF_OPT      12'hFF6
`define WDTUL_UNLOCK_1     8'h55
`define WDTUL_UNLOCK_2     8'hAA
`define WDTUL_RELOAD_RST   24'h000400
`define WDTUL_BIT_TMO      0
`define WDTUL_BIT_LOCKERR  1
`define WDTUL_OPT_RES_BIT  7
`define WDTUL_OPT_AO_BIT   6
`define WDTUL_OPT_ERASED   8'hFF
`define WDTUL_RST_TMO_BIT  5
`define WDTUL_TICK_DIV     16'd10000
`endif

// *** hdl/wdtul_pkg.sv ***
// types shared by the watchdog design files
package wdtul_pkg;
  typedef enum logic [1:0] {
    WDTUL_LOCKED,
    WDTUL_HALF,
    WDTUL_OPEN
  } wdtul_lock_e;
endpackage

// *** hdl/wdtul_sync.sv ***
// two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ns
module wdtul_sync
(
  input  wire logic clk_sys, // system clock
  input  wire logic rst_n,   // active-low reset
  input  wire logic d,       // asynchronous level
  output logic      q        // synchronised level
);
  logic meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// *** hdl/wdtul_counter.sv ***
// watchdog down counter with reload and zero detection
`timescale 1ns/1ns
module wdtul_counter
#(
  parameter int W = 24 // counter width
)
(
  input  wire logic         clk_sys,  // system clock
  input  wire logic         rst_n,    // active-low reset
  input  wire logic         run,      // counting allowed
  input  wire logic         tick,     // watchdog clock tick
  input  wire logic         reload,   // refresh instruction
  input  wire logic [W-1:0] value,    // reload value
  output logic [W-1:0]      count,    // live count
  output logic              timeout   // one-cycle zero pulse
);
  // refuse widths the zero detector cannot serve
  if (W < 2)
  begin
    $error("counter width too small");
  end

  wire hit_zero = run && tick && (count == {{(W-1){1'b0}}, 1'b1});

  // reload wins over counting; a tick at one reloads and pulses, a count of zero holds
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count   <= '1;
      timeout <= 1'b0;
    end
    else
    begin
      timeout <= hit_zero;
      if (reload || hit_zero)
        count <= value;
      else if (run && tick && count != '0)
        count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// *** hdl/wdtul_top.sv ***
// watchdog with unlock-guarded reload registers behind an apb slave
//
// Functional notes
// - Writing 55H then AAH to the control address unlocks the reload bytes.
// - Unlock writes only step the lock and change no stored control bit.
// - Control is write-only; reads there return the reset status.
// - The refresh instruction loads the 24-bit reload value into the count.
// - A permitted reload byte write updates that byte of the reload value.
// - Reading a reload byte returns that byte of the live count.
// - With the action bit 0, a time-out raises an interrupt request.
// - With the action bit 1 (erased default), a time-out resets the system.
// - With always-on 0 the watchdog runs from power-up and cannot stop.
// - Option bits come from the option byte and are captured again at every reset release.
//
// The implementer's own choice: the APB register port.
`include "wdtul_consts.svh"
`timescale 1ns/1ns
module wdtul_top
  import wdtul_pkg::*;
#(
  parameter logic [15:0] TICK_DIV = `WDTUL_TICK_DIV // sys clocks per tick
)
(
  input  wire logic        clk_sys,     // 100 MHz system clock
  input  wire logic        rstn,        // async active-low reset
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb enable
  input  wire logic        pwrite,      // apb direction
  input  wire logic [11:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  input  wire logic [7:0]  option_byte, // non-volatile option byte pins
  input  wire logic        refresh_instruction, // refresh pulse from cpu
  input  wire logic        run_enable,  // software enable when not always on
  output logic [31:0]      prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error
  output logic             irq,         // level interrupt
  output logic             sys_reset_req // time-out reset request
);
  logic rst_s1_reg, rst_n;
  logic opt_res, opt_ao, refresh_s, enable_s;
  logic [7:0]  opt_reg;
  logic [7:0]  opt_s1_reg, opt_s2_reg;
  logic        opt_valid_reg;
  wdtul_lock_e lock_reg, lock_next;
  logic [23:0] reload_reg, reload_next;
  logic [1:0]  stat_reg, mask_reg;
  logic        tmo_rst_flag_reg;
  logic [15:0] div_reg;
  logic        tick;
  logic [23:0] count;
  logic        timeout;
  logic        ready_reg;

  // a zero divider would wrap and tick only every 65536 clocks
  if (TICK_DIV == 16'h0000)
  begin
    $error("tick divider must be nonzero");
  end

  // reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // pin inputs enter through synchronisers
  wdtul_sync u_sync_ref
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (refresh_instruction),
    .q       (refresh_s)
  );
  wdtul_sync u_sync_en
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (run_enable),
    .q       (enable_s)
  );

  // option byte pins pass two flip-flops first
  always_ff @(posedge clk_sys)
  begin
    opt_s1_reg <= option_byte;
    opt_s2_reg <= opt_s1_reg;
  end

  // option byte caught once after each reset release, held until the next reset
  always_ff @(posedge clk_sys)
  begin
    if (!opt_valid_reg)
      opt_reg <= opt_s2_reg;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      opt_valid_reg <= 1'b0;
    else
      opt_valid_reg <= 1'b1;
  end
  assign opt_res = opt_valid_reg ? opt_reg[`WDTUL_OPT_RES_BIT] : 1'b1;
  assign opt_ao  = opt_valid_reg ? opt_reg[`WDTUL_OPT_AO_BIT]  : 1'b1;

  // apb decode
  wire acc      = psel && penable && ready_reg;
  wire wr       = acc && pwrite;
  wire rd       = acc && !pwrite;
  wire hit_ctl  = paddr == `WDTUL_OFF_CTL;
  wire hit_u    = paddr == `WDTUL_OFF_UPPER;
  wire hit_h    = paddr == `WDTUL_OFF_HIGH;
  wire hit_l    = paddr == `WDTUL_OFF_LOW;
  wire hit_stat = paddr == `WDTUL_OFF_STAT;
  wire hit_mask = paddr == `WDTUL_OFF_MASK;
  wire hit_opt  = paddr == `WDTUL_OFF_OPT;
  wire mapped   = hit_ctl | hit_u | hit_h | hit_l | hit_stat | hit_mask
                | hit_opt;
  wire [7:0] wbyte = pwdata[7:0];
  wire reload_wr   = wr && (hit_u || hit_h || hit_l);
  wire unlocked    = lock_reg == WDTUL_OPEN;
  wire locked_wr   = reload_wr && !unlocked;
  wire running     = !opt_ao ? 1'b0 : enable_s;
  wire run         = !opt_ao || running;

  // unlock sequencer, control writes store nothing
  always_comb
  begin
    lock_next = lock_reg;
    if (wr && hit_ctl)
    begin
      case (lock_reg)
        WDTUL_LOCKED: lock_next = (wbyte == `WDTUL_UNLOCK_1) ?
                                  WDTUL_HALF : WDTUL_LOCKED;
        WDTUL_HALF:   lock_next = (wbyte == `WDTUL_UNLOCK_2) ?
                                  WDTUL_OPEN : WDTUL_LOCKED;
        WDTUL_OPEN:   lock_next = (wbyte == `WDTUL_UNLOCK_1) ?
                                  WDTUL_HALF : WDTUL_LOCKED;
        default:      lock_next = WDTUL_LOCKED;
      endcase
    end
    else if (reload_wr)
      lock_next = WDTUL_LOCKED;
  end

  // reload byte updates only while unlocked
  always_comb
  begin
    reload_next = reload_reg;
    if (reload_wr && unlocked)
    begin
      if (hit_u) reload_next[23:16] = wbyte;
      if (hit_h) reload_next[15:8]  = wbyte;
      if (hit_l) reload_next[7:0]   = wbyte;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_reg   <= WDTUL_LOCKED;
      reload_reg <= `WDTUL_RELOAD_RST;
    end
    else
    begin
      lock_reg   <= lock_next;
      reload_reg <= reload_next;
    end
  end

  // watchdog tick prescaler
  assign tick = div_reg == '0;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      div_reg <= '0;
    else
      div_reg <= tick ? TICK_DIV - 16'd1 : div_reg - 16'd1;
  end

  wdtul_counter #(.W(24)) u_cnt
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (run),
    .tick    (tick),
    .reload  (refresh_s),
    .value   (reload_reg),
    .count   (count),
    .timeout (timeout)
  );

  // sticky status, set wins over write-one clear
  wire [1:0] ev = {locked_wr, timeout && !opt_res};
  wire [1:0] clr = (wr && hit_stat) ? pwdata[1:0] : 2'b00;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_reg <= 2'b00;
      mask_reg <= 2'b00;
    end
    else
    begin
      stat_reg <= (stat_reg & ~clr) | ev;
      if (wr && hit_mask)
        mask_reg <= pwdata[1:0];
    end
  end

  // time-out reset request and its status flag, reset straight from rstn
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sys_reset_req    <= 1'b0;
      tmo_rst_flag_reg <= 1'b0;
    end
    else
    begin
      sys_reset_req <= timeout && opt_res;
      if (timeout && opt_res)
        tmo_rst_flag_reg <= 1'b1;
      else if (rd && hit_ctl)
        tmo_rst_flag_reg <= 1'b0;
    end
  end

  // read mux: control address shows reset status, reload shows count
  wire [7:0] rst_stat = {2'b00, tmo_rst_flag_reg, 5'b00000};
  wire [7:0] rsel =
      hit_ctl  ? rst_stat :
      hit_u    ? count[23:16] :
      hit_h    ? count[15:8]  :
      hit_l    ? count[7:0]   :
      hit_stat ? {6'b000000, stat_reg} :
      hit_mask ? {6'b000000, mask_reg} :
      hit_opt  ? opt_reg : 8'h00;

  // one wait state per access, registered outputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_reg <= 1'b0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
      irq       <= 1'b0;
    end
    else
    begin
      ready_reg <= psel && penable && !ready_reg;
      pready    <= psel && penable && !ready_reg;
      pslverr   <= psel && penable && !ready_reg && !mapped;
      prdata    <= (psel && penable && !ready_reg && !pwrite) ?
                   {24'h000000, rsel} : 32'h0000_0000;
      irq       <= |((stat_reg | ev) & mask_reg);
    end
  end

  // checks
  property p_unlock_seq;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr && hit_ctl && wbyte == `WDTUL_UNLOCK_2 && lock_reg == WDTUL_HALF)
      |=> lock_reg == WDTUL_OPEN;
  endproperty
  a_unlock_seq: assert property (p_unlock_seq)
    else $error("unlock sequence did not open");

  property p_locked_keep;
    @(posedge clk_sys) disable iff (!rst_n)
    locked_wr |=> reload_reg == $past(reload_reg);
  endproperty
  a_locked_keep: assert property (p_locked_keep)
    else $error("locked reload write changed value");

  property p_ctl_nostore;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr && hit_ctl) |=> $stable(reload_reg) && $stable(mask_reg);
  endproperty
  a_ctl_nostore: assert property (p_ctl_nostore)
    else $error("control write changed stored bits");

  property p_reload_load;
    @(posedge clk_sys) disable iff (!rst_n)
    refresh_s |=> count == $past(reload_reg);
  endproperty
  a_reload_load: assert property (p_reload_load)
    else $error("refresh did not load count");

  property p_byte_upd;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr && hit_l && unlocked) |=> reload_reg[7:0] == $past(wbyte);
  endproperty
  a_byte_upd: assert property (p_byte_upd)
    else $error("low reload byte not updated");

  property p_read_count;
    @(posedge clk_sys) disable iff (!rst_n)
    (psel && penable && !ready_reg && !pwrite && hit_h)
      |=> prdata[7:0] == $past(count[15:8]);
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("reload read not live count");

  property p_ctl_read;
    @(posedge clk_sys) disable iff (!rst_n)
    (psel && penable && !ready_reg && !pwrite && hit_ctl)
      |=> prdata[`WDTUL_RST_TMO_BIT] == $past(tmo_rst_flag_reg);
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control read did not return reset status");

  property p_tmo_irq;
    @(posedge clk_sys) disable iff (!rst_n)
    (timeout && !opt_res) |=> stat_reg[`WDTUL_BIT_TMO];
  endproperty
  a_tmo_irq: assert property (p_tmo_irq)
    else $error("time-out interrupt not flagged");

  property p_tmo_rst;
    @(posedge clk_sys) disable iff (!rst_n)
    (timeout && opt_res) |=> sys_reset_req;
  endproperty
  a_tmo_rst: assert property (p_tmo_rst)
    else $error("time-out reset not requested");

  property p_always_on;
    @(posedge clk_sys) disable iff (!rst_n)
    (!opt_ao && tick && !refresh_s && count > 24'h000001)
      |=> count == $past(count) - 24'h000001;
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("always-on watchdog stopped");

  property p_opt_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    opt_valid_reg && $past(opt_valid_reg) |-> $stable(opt_reg);
  endproperty
  a_opt_hold: assert property (p_opt_hold)
    else $error("option byte changed");
endmodule

// *** sim/tb_top.sv ***
// self-checking apb bench for the unlock-guarded watchdog
`include "wdtul_consts.svh"
`timescale 1ns/1ns
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0]  option_byte = 8'hFF;
  logic        refresh_instruction = 1'b0;
  logic        run_enable = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        sys_reset_req;
  logic [31:0] rd;
  logic [31:0] first;
  logic        err;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          rst_pulses = 0;
  int          n;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  // counts time-out reset requests
  always @(posedge clk_sys)
    if (sys_reset_req === 1'b1)
      rst_pulses <= rst_pulses + 1;

  wdtul_top #(.TICK_DIV(16'h0004)) uut
  (
    .clk_sys             (clk_sys),
    .rstn                (rstn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .option_byte         (option_byte),
    .refresh_instruction (refresh_instruction),
    .run_enable          (run_enable),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .irq                 (irq),
    .sys_reset_req       (sys_reset_req)
  );

  // final verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // compare a register value
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // compare a single flag
  task automatic check_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // read and compare
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 8'h00);
    check_eq(rd, exp);
  endtask

  // two-byte unlock code at the control address
  task automatic unlock;
    apb(`WDTUL_OFF_CTL, 1'b1, `WDTUL_UNLOCK_1);
    apb(`WDTUL_OFF_CTL, 1'b1, `WDTUL_UNLOCK_2);
  endtask

  // one-cycle refresh pulse, then sync settling
  task automatic refresh;
    @(posedge clk_sys);
    refresh_instruction <= 1'b1;
    @(posedge clk_sys);
    refresh_instruction <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  // reset with a given option byte
  task automatic do_reset(input logic [7:0] opt);
    @(posedge clk_sys);
    rstn        <= 1'b0;
    option_byte <= opt;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask

  // reload value 0x000005, status cleared, then refresh
  task automatic short_reload;
    unlock;
    apb(`WDTUL_OFF_HIGH, 1'b1, 8'h00);
    unlock;
    apb(`WDTUL_OFF_LOW, 1'b1, 8'h05);
    apb(`WDTUL_OFF_STAT, 1'b1, 8'h03);
    refresh;
  endtask

  // hung-run guard
  initial
  begin
    #200000;
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    do_reset(8'hFF);
    rdchk(`WDTUL_OFF_OPT, 32'h000000FF);
    rdchk(`WDTUL_OFF_LOW, 32'h000000FF);
    rdchk(`WDTUL_OFF_UPPER, 32'h000000FF);
    refresh;
    rdchk(`WDTUL_OFF_HIGH, 32'h00000004);
    apb(`WDTUL_OFF_LOW, 1'b1, 8'h33);
    refresh;
    rdchk(`WDTUL_OFF_LOW, 32'h00000000);
    rdchk(`WDTUL_OFF_STAT, 32'h00000002);
    apb(`WDTUL_OFF_STAT, 1'b1, 8'h02);
    rdchk(`WDTUL_OFF_STAT, 32'h00000000);
    apb(`WDTUL_OFF_CTL, 1'b1, `WDTUL_UNLOCK_1);
    apb(`WDTUL_OFF_CTL, 1'b1, 8'h12);
    apb(`WDTUL_OFF_CTL, 1'b1, `WDTUL_UNLOCK_2);
    apb(`WDTUL_OFF_LOW, 1'b1, 8'h33);
    refresh;
    rdchk(`WDTUL_OFF_LOW, 32'h00000000);
    rdchk(`WDTUL_OFF_CTL, 32'h00000000);
    unlock;
    apb(`WDTUL_OFF_LOW, 1'b1, 8'h33);
    apb(`WDTUL_OFF_HIGH, 1'b1, 8'h22);
    refresh;
    rdchk(`WDTUL_OFF_LOW, 32'h00000033);
    rdchk(`WDTUL_OFF_HIGH, 32'h00000004);
    apb(12'h100, 1'b0, 8'h00);
    check_flag(err, 1'b1);
    $display("test registers done");
    do_reset(8'h7F);
    apb(`WDTUL_OFF_MASK, 1'b1, 8'h01);
    short_reload;
    run_enable <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 300)
    begin
      n++;
      @(posedge clk_sys);
    end
    check_flag(irq, 1'b1);
    check_flag(n >= 10 && n <= 30, 1'b1);
    check_flag(rst_pulses == 0, 1'b1);
    run_enable <= 1'b0;
    rdchk(`WDTUL_OFF_STAT, 32'h00000001);
    apb(`WDTUL_OFF_STAT, 1'b1, 8'h01);
    repeat (2) @(posedge clk_sys);
    check_flag(irq, 1'b0);
    apb(`WDTUL_OFF_MASK, 1'b1, 8'h00);
    run_enable <= 1'b1;
    repeat (60) @(posedge clk_sys);
    check_flag(irq, 1'b0);
    run_enable <= 1'b0;
    rdchk(`WDTUL_OFF_STAT, 32'h00000001);
    $display("test interrupt done");
    do_reset(8'hFF);
    apb(`WDTUL_OFF_MASK, 1'b1, 8'h01);
    short_reload;
    run_enable <= 1'b1;
    n = 0;
    while (rst_pulses == 0 && n < 300)
    begin
      n++;
      @(posedge clk_sys);
    end
    check_flag(rst_pulses > 0, 1'b1);
    check_flag(irq, 1'b0);
    run_enable <= 1'b0;
    rdchk(`WDTUL_OFF_CTL, 32'h00000020);
    rdchk(`WDTUL_OFF_CTL, 32'h00000000);
    $display("test reset action done");
    do_reset(8'hBF);
    rdchk(`WDTUL_OFF_OPT, 32'h000000BF);
    apb(`WDTUL_OFF_LOW, 1'b0, 8'h00);
    first = rd;
    repeat (20) @(posedge clk_sys);
    apb(`WDTUL_OFF_LOW, 1'b0, 8'h00);
    check_flag(rd !== first, 1'b1);
    $display("test always on done");
    end_of_test();
  end
endmodule
